// File: include/lspg_pkg.sv
// Purpose: Constants and types for the status LED pattern generator
// Assumes: 20 MHz system clock, APB register access
// Notes: All pattern times are in milliseconds of the divided tick
package lspg_pkg;
  // System clock and millisecond tick
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int TICK_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;

  // Pattern phase times in ms
  localparam logic [9:0] T_1HZ_MS = 10'h1F4;
  localparam logic [9:0] T_5HZ_MS = 10'h064;
  localparam logic [9:0] T_SYS_ON_MS = 10'h07D;
  localparam logic [9:0] T_SYS_OFF_MS = 10'h177;
  localparam logic [9:0] T_FLICK_MS = 10'h032;
  localparam logic [9:0] T_SELFTEST_MS = 10'h0FA;
  localparam logic [9:0] T_IDENT_MS = 10'h1F4;
  localparam logic [2:0] IDENT_REPEATS = 3'h6;
  // Activity hold: one full flicker period after the last frame
  localparam logic [6:0] TRAFFIC_HOLD_MS = 7'h64;

  // Register map
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int CTRL_TASK_LSB = 0;
  localparam int CTRL_ERR_LSB = 2;
  localparam int CTRL_ADAPTER = 4;
  localparam int CTRL_IP = 5;
  localparam int CTRL_TIMEOUT = 6;
  localparam int CTRL_SELFTEST = 7;
  localparam int CTRL_IDENT = 8;
  localparam int STAT_DUO_LSB = 0;
  localparam int STAT_LINK_LSB = 4;
  localparam int STAT_TRAFFIC_LSB = 6;
  localparam int STAT_SEQ_LSB = 8;
  localparam int STAT_IDBUSY = 11;

  typedef enum logic [1:0] {
    TASK_NOT_READY = 2'h0,
    TASK_UNCONFIGURED = 2'h1,
    TASK_WAITING = 2'h2,
    TASK_CONNECTED = 2'h3
  } lspg_task_t;

  typedef enum logic [1:0] {
    ERR_NONE = 2'h0,
    ERR_SYSTEM = 2'h1,
    ERR_COMM = 2'h2,
    ERR_SPARE = 2'h3
  } lspg_err_t;

  typedef enum logic [2:0] {
    C_OFF = 3'h0,
    C_GREEN = 3'h1,
    C_RED = 3'h2,
    C_G_1HZ = 3'h3,
    C_G_5HZ = 3'h4,
    C_R_1HZ = 3'h5,
    C_R_SYS = 3'h6
  } lspg_duo_mode_t;

  typedef enum logic [2:0] {
    SQ_IDLE = 3'h0,
    SQ_TEST_G = 3'h1,
    SQ_TEST_R = 3'h2,
    SQ_TEST_HOLD = 3'h3,
    SQ_ID_R = 3'h4,
    SQ_ID_G = 3'h5,
    SQ_ID_OFF = 3'h6
  } lspg_seq_t;
endpackage

// File: design/lspg_tick.sv
// Purpose: Millisecond tick divider
// Assumes: TICK_CYCLES at least 2
// Notes: Tick is a one-cycle enable pulse
`timescale 1ns/100ps
module lspg_tick
  import lspg_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic resetn,
  output logic tick
);
  logic [14:0] cnt_reg;
  logic [14:0] cnt_next;
  logic tick_reg;
  logic tick_next;
  logic wrap;

  always_comb begin
    wrap = (cnt_reg == 15'(TICK_CYCLES - 1));
    cnt_next = wrap ? 15'h0000 : cnt_reg + 15'h0001;
    tick_next = wrap;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      cnt_reg <= 15'h0000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

  a_tick_single: assert property (@(posedge clock) disable iff (!resetn)
    tick_reg |=> !tick_reg) else $error("tick lasted more than one cycle");
endmodule

// File: design/lspg_blinker.sv
// Purpose: On/off phase generator counted in millisecond ticks
// Assumes: on_ms and off_ms non-zero and stable while run is high
// Notes: Restart or run rising always begins with the lit phase
`timescale 1ns/100ps
module lspg_blinker
  import lspg_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic tick,
  input wire logic run,
  input wire logic restart,
  input wire logic [9:0] on_ms,
  input wire logic [9:0] off_ms,
  output logic lit
);
  logic [9:0] cnt_reg;
  logic [9:0] cnt_next;
  logic on_reg;
  logic on_next;
  logic lit_reg;
  logic lit_next;

  always_comb begin
    cnt_next = cnt_reg;
    on_next = on_reg;
    if (!run || restart) begin
      cnt_next = 10'h000;
      on_next = 1'b1;
    end else if (tick) begin
      if (on_reg && cnt_reg == on_ms - 10'h001) begin
        cnt_next = 10'h000;
        on_next = 1'b0;
      end else if (!on_reg && cnt_reg == off_ms - 10'h001) begin
        cnt_next = 10'h000;
        on_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 10'h001;
      end
    end
    lit_next = run && on_next;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      cnt_reg <= 10'h000;
      on_reg <= 1'b1;
      lit_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      on_reg <= on_next;
      lit_reg <= lit_next;
    end
  end

  assign lit = lit_reg;

  a_blink_restart: assert property (@(posedge clock) disable iff (!resetn)
    (run && restart) |=> lit_reg && cnt_reg == 10'h000) else $error("restart not lit");
  a_phase_bound: assert property (@(posedge clock) disable iff (!resetn)
    run && !restart |-> cnt_reg < (on_reg ? on_ms : off_ms)) else $error("phase overran its length");
endmodule

// File: design/lspg_led_ctrl.sv
// Purpose: Status indicator pattern generator with APB control
// Assumes: Link and frame inputs are asynchronous and synchronised here
// Notes: com0 is run or module state, com1 is error or network state
`timescale 1ns/100ps
module lspg_led_ctrl
  import lspg_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port_a_link,
  input wire logic port_b_link,
  input wire logic port_a_frame,
  input wire logic port_b_frame,
  output logic com0_green,
  output logic com0_red,
  output logic com1_green,
  output logic com1_red,
  output logic port_a_link_led,
  output logic port_b_link_led,
  output logic port_a_traffic_led,
  output logic port_b_traffic_led
);
  logic tick;
  logic [7:0] ctrl_reg, ctrl_next;
  logic ident_reg, ident_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [3:0] sync1_reg, sync2_reg;
  logic [1:0] link_reg, link_next;
  logic [1:0] traffic;
  lspg_duo_mode_t mode0, mode1, mode0_reg, mode1_reg;
  logic [9:0] on0, off0, on1, off1;
  logic lit0, lit1;
  lspg_seq_t seq_reg, seq_next;
  logic [9:0] ms_reg, ms_next;
  logic [2:0] rep_reg, rep_next;
  logic [3:0] duo_reg, duo_next;
  logic setup, access, st_on, in_test, done;
  logic [9:0] phase_ms;
  lspg_task_t task_sel;
  lspg_err_t err_sel;

  lspg_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clock(clock),
    .resetn(resetn),
    .tick(tick)
  );

  // APB slave, one wait-free access phase
  always_comb begin
    setup = psel && !penable;
    access = psel && penable && pready_reg;
    ctrl_next = ctrl_reg;
    ident_next = 1'b0;
    if (access && pwrite && paddr == ADDR_CTRL) begin
      ctrl_next = pwdata[7:0];
      ident_next = pwdata[CTRL_IDENT];
    end
    pready_next = setup;
    pslverr_next = setup && paddr != ADDR_CTRL && paddr != ADDR_STATUS;
    prdata_next = prdata_reg;
    if (setup) begin
      prdata_next = 32'h00000000;
      if (!pwrite && paddr == ADDR_CTRL) begin
        prdata_next[7:0] = ctrl_reg;
      end else if (!pwrite && paddr == ADDR_STATUS) begin
        prdata_next[STAT_DUO_LSB +: 4] = duo_reg;
        prdata_next[STAT_LINK_LSB +: 2] = link_reg;
        prdata_next[STAT_TRAFFIC_LSB +: 2] = traffic;
        prdata_next[STAT_SEQ_LSB +: 3] = seq_reg;
        prdata_next[STAT_IDBUSY] = seq_reg >= SQ_ID_R;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctrl_reg <= CTRL_RESET;
      ident_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      ident_reg <= ident_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Pin inputs pass two flops before use
  always_ff @(posedge clock) begin
    if (!resetn) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= {port_b_frame, port_a_frame, port_b_link, port_a_link};
      sync2_reg <= sync1_reg;
    end
  end

  always_comb begin
    link_next = sync2_reg[1:0];
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      link_reg <= 2'h0;
    end else begin
      link_reg <= link_next;
    end
  end

  // Per-port activity hold and flicker
  for (genvar p = 0; p < 2; p++) begin : g_port
    // Kept per port so each hold has a single writer
    logic [6:0] hold_reg;
    logic [6:0] hold_next;
    always_comb begin
      hold_next = hold_reg;
      if (sync2_reg[2 + p]) begin
        hold_next = TRAFFIC_HOLD_MS;
      end else if (tick && hold_reg != 7'h00) begin
        hold_next = hold_reg - 7'h01;
      end
    end

    always_ff @(posedge clock) begin
      if (!resetn) begin
        hold_reg <= 7'h00;
      end else begin
        hold_reg <= hold_next;
      end
    end

    lspg_blinker u_flick (
      .clock(clock),
      .resetn(resetn),
      .tick(tick),
      .run(hold_reg != 7'h00),
      .restart(1'b0),
      .on_ms(T_FLICK_MS),
      .off_ms(T_FLICK_MS),
      .lit(traffic[p])
    );
  end

  // Indicator state selection
  always_comb begin
    task_sel = lspg_task_t'(ctrl_reg[CTRL_TASK_LSB +: 2]);
    err_sel = lspg_err_t'(ctrl_reg[CTRL_ERR_LSB +: 2]);
    mode0 = C_OFF;
    mode1 = C_OFF;
    if (ctrl_reg[CTRL_ADAPTER]) begin
      mode0 = C_GREEN;
      if (!ctrl_reg[CTRL_IP]) begin
        mode1 = C_OFF;
      end else if (ctrl_reg[CTRL_TIMEOUT]) begin
        mode1 = C_R_1HZ;
      end else begin
        mode1 = C_GREEN;
      end
    end else begin
      case (task_sel)
        TASK_CONNECTED: mode0 = C_GREEN;
        TASK_UNCONFIGURED: mode0 = C_G_1HZ;
        TASK_WAITING: mode0 = C_G_5HZ;
        default: mode0 = C_OFF;
      endcase
      case (err_sel)
        ERR_COMM: mode1 = C_RED;
        ERR_SYSTEM: mode1 = C_R_SYS;
        default: mode1 = C_OFF;
      endcase
    end
    on0 = (mode0 == C_G_5HZ) ? T_5HZ_MS : T_1HZ_MS;
    off0 = on0;
    on1 = (mode1 == C_R_SYS) ? T_SYS_ON_MS : T_1HZ_MS;
    off1 = (mode1 == C_R_SYS) ? T_SYS_OFF_MS : T_1HZ_MS;
  end

  lspg_blinker u_blink0 (
    .clock(clock),
    .resetn(resetn),
    .tick(tick),
    .run(mode0 >= C_G_1HZ),
    .restart(mode0 != mode0_reg),
    .on_ms(on0),
    .off_ms(off0),
    .lit(lit0)
  );

  lspg_blinker u_blink1 (
    .clock(clock),
    .resetn(resetn),
    .tick(tick),
    .run(mode1 >= C_G_1HZ),
    .restart(mode1 != mode1_reg),
    .on_ms(on1),
    .off_ms(off1),
    .lit(lit1)
  );

  // Self-test and identify sequencer
  always_comb begin
    st_on = ctrl_reg[CTRL_ADAPTER] && ctrl_reg[CTRL_SELFTEST];
    in_test = seq_reg == SQ_TEST_G || seq_reg == SQ_TEST_R || seq_reg == SQ_TEST_HOLD;
    phase_ms = (seq_reg >= SQ_ID_R) ? T_IDENT_MS : T_SELFTEST_MS;
    done = tick && ms_reg == phase_ms - 10'h001;
    seq_next = seq_reg;
    rep_next = rep_reg;
    ms_next = tick ? ms_reg + 10'h001 : ms_reg;
    if (st_on && !in_test) begin
      seq_next = SQ_TEST_G;
      ms_next = 10'h000;
    end else if (!st_on && in_test) begin
      seq_next = SQ_IDLE;
    end else begin
      case (seq_reg)
        SQ_IDLE: begin
          ms_next = 10'h000;
          rep_next = 3'h0;
          // Identify only in adapter mode and only from idle
          if (ident_reg && ctrl_reg[CTRL_ADAPTER]) begin
            seq_next = SQ_ID_R;
          end
        end
        SQ_TEST_G: if (done) begin
          seq_next = SQ_TEST_R;
          ms_next = 10'h000;
        end
        SQ_TEST_R: if (done) begin
          seq_next = SQ_TEST_HOLD;
        end
        SQ_TEST_HOLD: ms_next = 10'h000;
        SQ_ID_R: if (done) begin
          seq_next = SQ_ID_G;
          ms_next = 10'h000;
        end
        SQ_ID_G: if (done) begin
          seq_next = SQ_ID_OFF;
          ms_next = 10'h000;
        end
        SQ_ID_OFF: if (done) begin
          ms_next = 10'h000;
          if (rep_reg == IDENT_REPEATS - 3'h1) begin
            seq_next = SQ_IDLE;
          end else begin
            seq_next = SQ_ID_R;
            rep_next = rep_reg + 3'h1;
          end
        end
        default: seq_next = SQ_IDLE;
      endcase
    end
  end

  always_comb begin
    case (seq_reg)
      SQ_TEST_G, SQ_TEST_HOLD, SQ_ID_G: duo_next = 4'h5;
      SQ_TEST_R, SQ_ID_R: duo_next = 4'hA;
      SQ_ID_OFF: duo_next = 4'h0;
      default: begin
        duo_next[0] = mode0 == C_GREEN || ((mode0 == C_G_1HZ || mode0 == C_G_5HZ) && lit0);
        duo_next[1] = 1'b0;
        duo_next[2] = mode1 == C_GREEN;
        duo_next[3] = mode1 == C_RED || ((mode1 == C_R_1HZ || mode1 == C_R_SYS) && lit1);
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      seq_reg <= SQ_IDLE;
      ms_reg <= 10'h000;
      rep_reg <= 3'h0;
      mode0_reg <= C_OFF;
      mode1_reg <= C_OFF;
      duo_reg <= 4'h0;
    end else begin
      seq_reg <= seq_next;
      ms_reg <= ms_next;
      rep_reg <= rep_next;
      mode0_reg <= mode0;
      mode1_reg <= mode1;
      duo_reg <= duo_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign com0_green = duo_reg[0];
  assign com0_red = duo_reg[1];
  assign com1_green = duo_reg[2];
  assign com1_red = duo_reg[3];
  assign port_a_link_led = link_reg[0];
  assign port_b_link_led = link_reg[1];
  assign port_a_traffic_led = traffic[0];
  assign port_b_traffic_led = traffic[1];

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_test_green;
    seq_reg == SQ_TEST_G ##1 seq_reg == SQ_TEST_G;
  endsequence

  a_duo_exclusive: assert property (!(duo_reg[0] && duo_reg[1]) && !(duo_reg[2] && duo_reg[3]))
    else $error("duo lit both colours");
  a_reset_dark: assert property (@(posedge clock) disable iff (1'b0)
    !resetn |=> duo_reg == 4'h0 && !traffic[0] && !traffic[1]) else $error("not dark");
  a_run_steady: assert property (seq_reg == SQ_IDLE && seq_next == SQ_IDLE && mode0 == C_GREEN
    |=> com0_green && !com0_red) else $error("run not steady green");
  a_run_dark: assert property (!ctrl_reg[CTRL_ADAPTER] && task_sel == TASK_NOT_READY
    && seq_reg == SQ_IDLE |=> !com0_green && !com0_red) else $error("run not dark");
  a_err_comm: assert property (!ctrl_reg[CTRL_ADAPTER] && err_sel == ERR_COMM
    && seq_reg == SQ_IDLE |=> com1_red) else $error("comm error not red");
  a_link_follow: assert property (sync2_reg[0] |=> port_a_link_led)
    else $error("link LED not lit");
  a_no_ip_dark: assert property (ctrl_reg[CTRL_ADAPTER] && !ctrl_reg[CTRL_IP]
    && seq_reg == SQ_IDLE |=> !com1_green && !com1_red) else $error("no IP not dark");
  a_ident_count: assert property (seq_reg == SQ_ID_OFF && done && !st_on
    && rep_reg != IDENT_REPEATS - 3'h1
    |=> seq_reg == SQ_ID_R) else $error("identify ended early");
  a_test_order: assert property (s_test_green |-> com0_green && com1_green)
    else $error("self-test not green");
  a_traffic_idle: assert property (g_port[0].hold_reg == 7'h00 |=> !port_a_traffic_led)
    else $error("traffic lit without frames");
endmodule

// File: testbench/lspg_led_panel.sv
// Purpose: Front panel model of the duo and single colour status LEDs
// Assumes: A lamp follows its drive with no delay
// Notes: Clash latches if a duo element ever shows both colours at once
`timescale 1ns/100ps
module lspg_led_panel (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] drive,
  output logic [7:0] lamps,
  output logic clash
);
  assign lamps = drive;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      clash <= 1'b0;
    end else if ((drive[0] && drive[1]) || (drive[2] && drive[3])) begin
      clash <= 1'b1;
    end
  end
endmodule

// File: testbench/lspg_led_ctrl_tb.sv
// Purpose: Self-checking bench for the status LED pattern generator
// Assumes: One ms tick is TK clocks, so phase lengths are short in cycles
// Notes: Phase lengths are accepted within one tick plus one clock either way
`timescale 1ns/100ps
module lspg_led_ctrl_tb;
  import lspg_pkg::*;
  localparam int TK = 4;
  logic clock = 1'b0;
  logic resetn, psel, penable, pwrite, pready, pslverr, er, clash;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic port_a_link, port_b_link, port_a_frame, port_b_frame;
  logic com0_green, com0_red, com1_green, com1_red;
  logic port_a_link_led, port_b_link_led, port_a_traffic_led, port_b_traffic_led;
  logic [7:0] lamps;
  logic [3:0] snap [3];
  int fail_count = 0;
  int n_checks = 0;
  int rises;
  logic prev;
  always #25 clock = ~clock;
  lspg_led_ctrl #(.TICK_CYCLES(TK)) u_lspg_led_ctrl (.clock, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .port_a_link, .port_b_link,
    .port_a_frame, .port_b_frame, .com0_green, .com0_red, .com1_green, .com1_red,
    .port_a_link_led, .port_b_link_led, .port_a_traffic_led, .port_b_traffic_led);
  lspg_led_panel u_lspg_led_panel (.clock, .resetn, .lamps, .clash,
    .drive({port_b_traffic_led, port_a_traffic_led, port_b_link_led, port_a_link_led,
      com1_red, com1_green, com0_red, com0_green}));
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic bad(input logic [31:0] got, input logic [31:0] exp);
    fail_count++;
    $display("wrong value at %0t: got %h expected %h", $time, got, exp);
  endtask
  task automatic hang();
    bad(32'h0, 32'h1);
    summarize();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad(got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      hang();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic set_ctrl(input logic [31:0] v);
    apb(1'b1, ADDR_CTRL, v);
    repeat (4) @(posedge clock);
  endtask
  // Skips a phase already running so only whole phases are timed
  task automatic measure(input int idx, input logic lvl, input int exp);
    int i;
    int n;
    i = 0;
    n = 0;
    while (lamps[idx] === lvl && i < 9000) begin
      @(posedge clock);
      i++;
    end
    while (lamps[idx] !== lvl && i < 9000) begin
      @(posedge clock);
      i++;
    end
    while (lamps[idx] === lvl && i < 9000) begin
      @(posedge clock);
      i++;
      n++;
    end
    if (i >= 9000) begin
      hang();
    end
    n_checks++;
    if (n < exp - TK - 1 || n > exp + TK + 1) begin
      bad(n, exp);
    end
  endtask
  initial begin
    resetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {port_a_link, port_b_link, port_a_frame, port_b_frame} = 4'h0;
    repeat (12) @(posedge clock);
    chk(lamps, 8'h00);
    resetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'(CTRL_RESET));
    apb(1'b0, 12'h008, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    $display("test reset and bus done");
    set_ctrl(32'h3);
    chk(lamps[3:0], 4'h1);
    set_ctrl(32'h0);
    chk(lamps[3:0], 4'h0);
    set_ctrl(32'h3);
    set_ctrl(32'h1);
    measure(0, 1'b1, int'(T_1HZ_MS) * TK);
    measure(0, 1'b0, int'(T_1HZ_MS) * TK);
    set_ctrl(32'h2);
    measure(0, 1'b1, int'(T_5HZ_MS) * TK);
    measure(0, 1'b0, int'(T_5HZ_MS) * TK);
    set_ctrl(32'hA);
    chk(lamps[3:2], 2'h2);
    set_ctrl(32'h4);
    measure(3, 1'b1, int'(T_SYS_ON_MS) * TK);
    measure(3, 1'b0, int'(T_SYS_OFF_MS) * TK);
    set_ctrl(32'h0);
    chk(lamps[3:0], 4'h0);
    $display("test run and error done");
    port_a_link <= 1'b1;
    repeat (5) @(posedge clock);
    chk(lamps[5:4], 2'h1);
    port_a_link <= 1'b0;
    port_b_link <= 1'b1;
    repeat (5) @(posedge clock);
    chk(lamps[5:4], 2'h2);
    port_b_link <= 1'b0;
    port_b_frame <= 1'b1;
    repeat (2) @(posedge clock);
    port_b_frame <= 1'b0;
    measure(7, 1'b1, int'(T_FLICK_MS) * TK);
    chk(lamps[6], 1'b0);
    repeat (int'(T_FLICK_MS) * TK * 3) @(posedge clock);
    chk(lamps[7:6], 2'h0);
    port_a_frame <= 1'b1;
    repeat (2) @(posedge clock);
    port_a_frame <= 1'b0;
    repeat (6) @(posedge clock);
    chk(lamps[7:6], 2'h1);
    repeat (int'(T_FLICK_MS) * TK * 3) @(posedge clock);
    chk(lamps[7:6], 2'h0);
    $display("test link and traffic done");
    set_ctrl(32'h10);
    chk(lamps[3:0], 4'h1);
    set_ctrl(32'h70);
    measure(3, 1'b1, int'(T_1HZ_MS) * TK);
    set_ctrl(32'hB0);
    chk(lamps[1:0], 2'h1);
    measure(1, 1'b1, int'(T_SELFTEST_MS) * TK);
    repeat (20) @(posedge clock);
    chk(lamps[1:0], 2'h1);
    set_ctrl(32'h30);
    $display("test adapter and self-test done");
    apb(1'b1, ADDR_CTRL, 32'h130);
    rises = 0;
    prev = lamps[1];
    for (int k = 0; k < int'(T_IDENT_MS) * TK * 19; k++) begin
      @(posedge clock);
      if (k == 8) snap[0] = lamps[3:0];
      if (k == int'(T_IDENT_MS) * TK * 3 / 2) snap[1] = lamps[3:0];
      if (k == int'(T_IDENT_MS) * TK * 5 / 2) snap[2] = lamps[3:0];
      if (lamps[1] && !prev) rises++;
      prev = lamps[1];
    end
    chk(snap[0], 4'hA);
    chk(snap[1], 4'h5);
    chk(snap[2], 4'h0);
    chk(rises, 32'(IDENT_REPEATS));
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[STAT_IDBUSY], 1'b0);
    chk(rd[3:0], 4'h5);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h30);
    chk(clash, 1'b0);
    $display("test identify done");
    summarize();
  end
endmodule
